/* File: src/sgerr_params.svh */
// sgerr_params.svh: offsets, bit positions and reset values
// of the secure global error block.
// assumes: included by the package and design files by bare name.
`ifndef SGERR_PARAMS_SVH
`define SGERR_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SGERR_OFF_STATUS 16'h8060
`define SGERR_OFF_ACK 16'h8064
`define SGERR_OFF_MADDR_LO 16'h8068
`define SGERR_OFF_MADDR_HI 16'h806C

// ----------------------------------------------------------------
// flag bit positions and field layout
// ----------------------------------------------------------------
`define SGERR_NFLAG 10
`define SGERR_BIT_CMDQ 0
`define SGERR_BIT_EVQ_ABT 2
`define SGERR_BIT_SYNC_MSG 4
`define SGERR_BIT_EVT_MSG 5
`define SGERR_BIT_ERR_MSG 7
`define SGERR_BIT_SFM 8
`define SGERR_BIT_CMDQP 9
`define SGERR_DEFINED_MASK 10'h3B5
`define SGERR_FLAG_RESET 1'b0
`define SGERR_ADDR_W 50
`define SGERR_ADDR_LO_W 30
`define SGERR_ADDR_HI_W 20
`define SGERR_REASON_W 7
`define SGERR_PA_SIZE 48

`endif

/* File: src/sgerr_pkg.sv */
// sgerr_pkg: state types of the secure global error block.
// assumes: sgerr_params.svh is on the include path.
`include "sgerr_params.svh"

package sgerr_pkg;

    // ----------------------------------------------------------------
    // one toggle pair
    // ----------------------------------------------------------------
    typedef struct packed {
        logic st;
        logic ak;
    } sgerr_flag_t;

    typedef enum logic {SGERR_IDLE, SGERR_SEND} sgerr_nstate_t;

    typedef struct packed {
        sgerr_nstate_t state;
        logic pend;
        logic req;
        logic [63:0] addr;
        logic irq;
        logic abt;
    } sgerr_notify_t;

    typedef struct packed {
        logic sfm_mode;
        logic [`SGERR_REASON_W-1:0] reason;
        logic [`SGERR_ADDR_W-1:0] addr;
        logic [`SGERR_NFLAG-1:0] act;
        logic [31:0] rdata;
        logic ready;
    } sgerr_core_t;

endpackage

/* File: src/sgerr_flag.sv */
// sgerr_flag: one status/acknowledge toggle pair.
// assumes: event and write strobes are synchronous to core_clk_in.
`timescale 1ns/1ps
`include "sgerr_params.svh"

module sgerr_flag (
    input wire logic core_clk_in, // core clock
    input wire logic rst_in, // async reset, high
    input wire logic event_in, // error occurrence pulse
    input wire logic ack_we_in, // software write of ack bit
    input wire logic ack_wdata_in, // written ack value
    output logic status_out, // status bit
    output logic ack_out, // acknowledge bit
    output logic active_out, // error active
    output logic taken_out // occurrence recorded this cycle
);
    sgerr_pkg::sgerr_flag_t s, next_s;

    // toggle status only while inactive against the new ack value
    always_comb begin
        next_s = s;
        if (ack_we_in) begin
            next_s.ak = ack_wdata_in;
        end
        taken_out = event_in && (s.st == next_s.ak);
        if (taken_out) begin
            next_s.st = ~s.st;
        end
    end

    // state register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '{st: `SGERR_FLAG_RESET, ak: `SGERR_FLAG_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign status_out = s.st;
    assign ack_out = s.ak;
    assign active_out = s.st ^ s.ak;
endmodule // sgerr_flag

/* File: src/sgerr_notify.sv */
// sgerr_notify: wired pulse or message write on new errors.
// assumes: message port answers each request with done or abort.
`timescale 1ns/1ps

module sgerr_notify (
    input wire logic core_clk_in, // core clock
    input wire logic rst_in, // async reset, high
    input wire logic trigger_in, // an error became active
    input wire logic enable_in, // error interrupt enable
    input wire logic [63:0] addr_in, // effective message address
    input wire logic msg_done_in, // message write completed
    input wire logic msg_abort_in, // message write aborted
    output logic msg_req_out, // message write request
    output logic [63:0] msg_addr_out, // message target
    output logic wired_irq_out, // wired interrupt pulse
    output logic abort_event_out // own message aborted pulse
);
    sgerr_pkg::sgerr_notify_t s, next_s;

    // one message in flight, one more kept pending
    always_comb begin
        next_s = s;
        next_s.irq = 1'b0;
        next_s.abt = 1'b0;
        if (trigger_in && enable_in) begin
            if (addr_in == 64'h0) begin
                next_s.irq = 1'b1;
            end else begin
                next_s.pend = 1'b1;
            end
        end
        case (s.state)
            sgerr_pkg::SGERR_IDLE: begin
                if (s.pend) begin
                    next_s.pend = 1'b0;
                end
                if (s.pend && (addr_in != 64'h0)) begin
                    next_s.req = 1'b1;
                    next_s.addr = addr_in;
                    next_s.state = sgerr_pkg::SGERR_SEND;
                end
            end
            sgerr_pkg::SGERR_SEND: begin
                if (msg_done_in || msg_abort_in) begin
                    next_s.req = 1'b0;
                    next_s.abt = msg_abort_in;
                    next_s.state = sgerr_pkg::SGERR_IDLE;
                end
            end
            default: next_s.state = sgerr_pkg::SGERR_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign msg_req_out = s.req;
    assign msg_addr_out = s.addr;
    assign wired_irq_out = s.irq;
    assign abort_event_out = s.abt;
endmodule // sgerr_notify

/* File: src/sgerr_core.sv */
// sgerr_core: secure global error recording with its registers.
// assumes: all inputs are synchronous to core_clk_in; register
// accesses are single-cycle strobes answered one cycle later.
//
// Contract
// - error active while status differs from ack
// - hardware toggles status bit on new error
// - no toggle while error already active
// - service failure stops traffic, commands, events
// - ack clears flag, failure mode persists
// - bit 9 command page errors if present
// - bit 7 error message write aborted
// - bit 5 event, bit 4 sync message aborts
// - abort flags never alter later messages
// - bit 2 event queue access aborted
// - bit 0 command error, reason, stop
// - no commands while command error active
// - all defined flags reset to zero
// - reserved bits read zero in both registers
// - status 0x8060, ack 0x8064, address 0x8068
// - non-secure access reads zero, ignores writes
// - address register holds bits 51 to 2
// - effective address zero above size, low bits
// - zero address sends no message, wired instead
// - address writable only with both enables zero
// - absent secure interface reads zero everywhere
// - enable bit gates error interrupts
`timescale 1ns/1ps
`include "sgerr_params.svh"

module sgerr_core #(
    parameter bit SECURE_PRESENT = 1'b1, // secure_interface_present
    parameter bit MSG_PRESENT = 1'b1, // message interrupts supported
    parameter bit ECMDQ_PRESENT = 1'b1, // secure extended queue pages
    parameter int PA_SIZE = `SGERR_PA_SIZE // physical_address_size
) (
    input wire logic core_clk_in, // core clock, 25 MHz
    input wire logic rst_in, // async reset, high
    // register access
    input wire logic reg_sel_in, // access strobe
    input wire logic reg_wr_in, // 1 write, 0 read
    input wire logic reg_nonsecure_in, // access is non-secure
    input wire logic [15:0] reg_addr_in, // byte offset
    input wire logic [31:0] reg_wdata_in, // write data
    output logic [31:0] reg_rdata_out, // read data
    output logic reg_ready_out, // answer pulse
    // error sources
    input wire logic cmdq_error_in, // command cannot be processed
    input wire logic [`SGERR_REASON_W-1:0] cmdq_reason_in, // its reason
    input wire logic event_queue_abort_in, // event queue access aborted
    input wire logic sync_msg_abort_in, // sync message aborted
    input wire logic event_msg_abort_in, // event message aborted
    input wire logic command_page_error_in, // control page error
    input wire logic service_failure_in, // service failure entered
    input wire logic service_recover_in, // recovery from failure mode
    // interrupt control
    input wire logic secure_error_irq_enable_in, // enable bit
    input wire logic irq_enable_acknowledge_in, // its ack copy
    // message port
    input wire logic msg_done_in, // message write completed
    input wire logic msg_abort_in, // message write aborted
    output logic msg_req_out, // message write request
    output logic [63:0] msg_addr_out, // message target
    output logic wired_irq_out, // wired interrupt pulse
    // status to the rest of the unit
    output logic [`SGERR_NFLAG-1:0] error_active_out, // active errors
    output logic [`SGERR_REASON_W-1:0] command_consumer_reason_code_out, // reason
    output logic command_stop_out, // command processing halted
    output logic traffic_stop_out, // traffic halted
    output logic event_stop_out, // event recording halted
    output logic service_failure_mode_out // failure mode held
);
    // ----------------------------------------------------------------
    // implemented flags and address keep mask
    // ----------------------------------------------------------------
    localparam logic [`SGERR_NFLAG-1:0] FEAT = {ECMDQ_PRESENT, 1'b1,
        MSG_PRESENT, 1'b0, MSG_PRESENT, MSG_PRESENT, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [`SGERR_NFLAG-1:0] IMPL =
        FEAT & `SGERR_DEFINED_MASK & {`SGERR_NFLAG{SECURE_PRESENT}};
    localparam logic [63:0] PA_KEEP = (PA_SIZE >= 64) ? {64{1'b1}} :
        ((64'h1 << PA_SIZE) - 64'h1);
    localparam logic [`SGERR_ADDR_W-1:0] ADDR_KEEP =
        PA_KEEP[`SGERR_ADDR_W+1:2];

    sgerr_pkg::sgerr_core_t s, next_s;

    logic [`SGERR_NFLAG-1:0] raw_ev;
    logic [`SGERR_NFLAG-1:0] ev;
    logic [`SGERR_NFLAG-1:0] ack_we;
    logic [`SGERR_NFLAG-1:0] status;
    logic [`SGERR_NFLAG-1:0] ack;
    logic [`SGERR_NFLAG-1:0] active;
    logic [`SGERR_NFLAG-1:0] taken;
    logic err_msg_abort;
    logic sec_acc;
    logic addr_open;
    logic [63:0] eff_addr;

    // ----------------------------------------------------------------
    // error sources onto flag positions
    // ----------------------------------------------------------------
    always_comb begin
        raw_ev = '0;
        raw_ev[`SGERR_BIT_CMDQ] = cmdq_error_in;
        raw_ev[`SGERR_BIT_EVQ_ABT] = event_queue_abort_in;
        raw_ev[`SGERR_BIT_SYNC_MSG] = sync_msg_abort_in;
        raw_ev[`SGERR_BIT_EVT_MSG] = event_msg_abort_in;
        raw_ev[`SGERR_BIT_ERR_MSG] = err_msg_abort;
        raw_ev[`SGERR_BIT_SFM] = service_failure_in;
        raw_ev[`SGERR_BIT_CMDQP] = command_page_error_in;
    end

    assign ev = raw_ev & IMPL;

    // secure accesses only; absent interface acts as reserved
    assign sec_acc = reg_sel_in && !reg_nonsecure_in && SECURE_PRESENT;

    // ack writes reach implemented bits only
    assign ack_we = (sec_acc && reg_wr_in && (reg_addr_in == `SGERR_OFF_ACK)) ? IMPL : '0;

    // ----------------------------------------------------------------
    // toggle pairs, one per implemented flag
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SGERR_NFLAG; gi++) begin : g_flag
            if (IMPL[gi]) begin : g_impl
                sgerr_flag u_flag (
                    .core_clk_in(core_clk_in),
                    .rst_in(rst_in),
                    .event_in(ev[gi]),
                    .ack_we_in(ack_we[gi]),
                    .ack_wdata_in(reg_wdata_in[gi]),
                    .status_out(status[gi]),
                    .ack_out(ack[gi]),
                    .active_out(active[gi]),
                    .taken_out(taken[gi])
                );
            end else begin : g_rsvd
                assign {status[gi], ack[gi], active[gi], taken[gi]} = 4'h0;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // message address guard and effective address
    // ----------------------------------------------------------------
    assign addr_open = !secure_error_irq_enable_in && !irq_enable_acknowledge_in;
    assign eff_addr = {12'h000, s.addr, 2'b00} & PA_KEEP;

    // ----------------------------------------------------------------
    // failure mode, reason code and register file
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.ready = reg_sel_in;
        next_s.rdata = 32'h0;
        next_s.act = active;
        // recovery clears the mode, a new failure wins over it
        if (service_recover_in) begin
            next_s.sfm_mode = 1'b0;
        end
        if (ev[`SGERR_BIT_SFM]) begin
            next_s.sfm_mode = 1'b1;
        end
        // reason only when the command error is newly recorded
        if (taken[`SGERR_BIT_CMDQ]) begin
            next_s.reason = cmdq_reason_in;
        end
        // address decode
        if (sec_acc) begin
            if (reg_addr_in == `SGERR_OFF_STATUS) begin
                next_s.rdata = {22'h0, status};
            end else if (reg_addr_in == `SGERR_OFF_ACK) begin
                next_s.rdata = {22'h0, ack};
            end else if (MSG_PRESENT && (reg_addr_in == `SGERR_OFF_MADDR_LO)) begin
                next_s.rdata = {s.addr[`SGERR_ADDR_LO_W-1:0], 2'b00};
                if (reg_wr_in && addr_open) begin
                    next_s.addr[`SGERR_ADDR_LO_W-1:0] =
                        reg_wdata_in[31:2] & ADDR_KEEP[`SGERR_ADDR_LO_W-1:0];
                end
            end else if (MSG_PRESENT && (reg_addr_in == `SGERR_OFF_MADDR_HI)) begin
                next_s.rdata = {12'h000, s.addr[`SGERR_ADDR_W-1:`SGERR_ADDR_LO_W]};
                if (reg_wr_in && addr_open) begin
                    next_s.addr[`SGERR_ADDR_W-1:`SGERR_ADDR_LO_W] =
                        reg_wdata_in[`SGERR_ADDR_HI_W-1:0] &
                        ADDR_KEEP[`SGERR_ADDR_W-1:`SGERR_ADDR_LO_W];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // interrupt and message sender
    // ----------------------------------------------------------------
    sgerr_notify u_notify (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .trigger_in(|(active & ~s.act)),
        .enable_in(secure_error_irq_enable_in),
        .addr_in(MSG_PRESENT ? eff_addr : 64'h0),
        .msg_done_in(msg_done_in),
        .msg_abort_in(msg_abort_in),
        .msg_req_out(msg_req_out),
        .msg_addr_out(msg_addr_out),
        .wired_irq_out(wired_irq_out),
        .abort_event_out(err_msg_abort)
    );

    // outputs
    assign reg_rdata_out = s.rdata;
    assign reg_ready_out = s.ready;
    assign error_active_out = active;
    assign command_consumer_reason_code_out = s.reason;
    // commands halt on command error or failure mode
    assign command_stop_out = active[`SGERR_BIT_CMDQ] || s.sfm_mode;
    assign traffic_stop_out = s.sfm_mode;
    assign event_stop_out = s.sfm_mode;
    assign service_failure_mode_out = s.sfm_mode;
endmodule // sgerr_core

/* File: bench/sgerr_msg_model.sv */
// sgerr_msg_model: message target that answers requests of the block.
// assumes: one clock; a request is held until it is answered.
`timescale 1ns/1ps

module sgerr_msg_model (
    input logic core_clk_in, // core clock
    input logic rst_in, // async reset, high
    input logic msg_req_in, // request from the block
    input logic abort_mode_in, // answer with abort
    input logic [3:0] delay_in, // answer delay in cycles
    output logic msg_done_out, // write completed
    output logic msg_abort_out // write aborted
);
    logic [3:0] wait_cnt;
    logic answered;

    // one answer per request after the delay, then wait for release
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_cnt <= 4'h0;
            answered <= 1'b0;
            msg_done_out <= 1'b0;
            msg_abort_out <= 1'b0;
        end else begin
            msg_done_out <= 1'b0;
            msg_abort_out <= 1'b0;
            if (!msg_req_in) begin
                wait_cnt <= 4'h0;
                answered <= 1'b0;
            end else if (!answered && wait_cnt == delay_in) begin
                msg_done_out <= !abort_mode_in;
                msg_abort_out <= abort_mode_in;
                answered <= 1'b1;
            end else if (!answered) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule // sgerr_msg_model

/* File: bench/sgerr_core_sva.sv */
// sgerr_core_sva: port checks of the secure global error block.
// assumes: bound to sgerr_core; one clock, async reset high.
`timescale 1ns/1ps
`include "sgerr_params.svh"

module sgerr_core_sva #(
    parameter int PA_SIZE = `SGERR_PA_SIZE // physical_address_size
) (
    input logic core_clk_in, // core clock
    input logic rst_in, // async reset
    input logic reg_sel_in, // access strobe
    input logic reg_wr_in, // write flag
    input logic reg_nonsecure_in, // non-secure access
    input logic [31:0] reg_rdata_out, // read data
    input logic reg_ready_out, // answer pulse
    input logic cmdq_error_in, // command error pulse
    input logic [`SGERR_REASON_W-1:0] cmdq_reason_in, // its reason
    input logic service_failure_in, // failure entry
    input logic service_recover_in, // failure exit
    input logic msg_done_in, // message done
    input logic msg_abort_in, // message aborted
    input logic msg_req_out, // message request
    input logic [63:0] msg_addr_out, // message target
    input logic [`SGERR_NFLAG-1:0] error_active_out, // active flags
    input logic [`SGERR_REASON_W-1:0] command_consumer_reason_code_out, // reason
    input logic command_stop_out, // command halt
    input logic traffic_stop_out, // traffic halt
    input logic event_stop_out, // event halt
    input logic service_failure_mode_out // failure mode
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic sw_wr;
    assign sw_wr = reg_sel_in && reg_wr_in;
    // ----------------------------------------------------------------
    // message steps
    // ----------------------------------------------------------------
    sequence s_msg_wait;
        msg_req_out && !msg_done_in && !msg_abort_in;
    endsequence
    sequence s_own_abort;
        msg_req_out && msg_abort_in && !error_active_out[7] && !sw_wr;
    endsequence
    a_answer_next: assert property (reg_sel_in |=> reg_ready_out)
        else $error("no answer after access");
    a_nonsec_zero: assert property (reg_sel_in && reg_nonsecure_in |=> reg_rdata_out == 32'h0)
        else $error("non-secure read not zero");
    a_reserved_idle: assert property ((error_active_out & ~`SGERR_DEFINED_MASK) == 10'h000)
        else $error("reserved flag active");
    a_cmdq_record: assert property (cmdq_error_in && !error_active_out[0] && !sw_wr |=>
        error_active_out[0] && command_consumer_reason_code_out == $past(cmdq_reason_in))
        else $error("command error not recorded");
    a_cmdq_halt: assert property (error_active_out[0] |-> command_stop_out)
        else $error("commands run during command error");
    a_active_held: assert property (error_active_out[2] && !sw_wr |=> error_active_out[2])
        else $error("active flag changed without ack");
    a_fail_stop: assert property (service_failure_in |=> traffic_stop_out && event_stop_out
        && command_stop_out && service_failure_mode_out)
        else $error("failure mode did not stop work");
    a_fail_persist: assert property (service_failure_mode_out && !service_recover_in |=>
        service_failure_mode_out)
        else $error("failure mode left without recovery");
    a_msg_hold: assert property (s_msg_wait |=> msg_req_out && $stable(msg_addr_out))
        else $error("message request not held");
    a_msg_shape: assert property (msg_req_out |-> msg_addr_out != 64'h0
        && msg_addr_out[1:0] == 2'h0 && (msg_addr_out >> PA_SIZE) == 64'h0)
        else $error("bad message address");
    a_abort_flag: assert property (s_own_abort |-> ##[1:3] error_active_out[7])
        else $error("aborted message not flagged");
endmodule // sgerr_core_sva

bind sgerr_core sgerr_core_sva #(.PA_SIZE(PA_SIZE)) u_sva (
    .core_clk_in, .rst_in, .reg_sel_in, .reg_wr_in, .reg_nonsecure_in, .reg_rdata_out,
    .reg_ready_out, .cmdq_error_in, .cmdq_reason_in, .service_failure_in,
    .service_recover_in, .msg_done_in, .msg_abort_in, .msg_req_out, .msg_addr_out,
    .error_active_out, .command_consumer_reason_code_out, .command_stop_out,
    .traffic_stop_out, .event_stop_out, .service_failure_mode_out);

/* File: bench/tb.sv */
// tb: register level tests of the secure global error block.
// assumes: sgerr_core with default parameters, message model at far side.
`timescale 1ns/1ps
`include "sgerr_params.svh"

module tb;
    logic core_clk_in, rst_in, sel, wr, ns, ready, req, done, abt, irq, en, enack, recov;
    logic ctstop, trstop, evstop, fmode, abort_mode, saw_req, saw_irq;
    logic [15:0] addr;
    logic [31:0] wd, rdata, q;
    logic [3:0] dly;
    logic [9:0] evp, act, sv, pend;
    logic [6:0] rs, reason_code;
    logic [63:0] maddr, seen_addr;
    int num_errors, checks_done;
    int bits[5] = '{0, 2, 4, 5, 9};

    sgerr_core uut (.core_clk_in, .rst_in, .reg_sel_in(sel),
        .reg_wr_in(wr), .reg_nonsecure_in(ns), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_rdata_out(rdata), .reg_ready_out(ready), .cmdq_error_in(evp[0]),
        .cmdq_reason_in(rs), .event_queue_abort_in(evp[2]), .sync_msg_abort_in(evp[4]),
        .event_msg_abort_in(evp[5]), .command_page_error_in(evp[9]),
        .service_failure_in(evp[8]), .service_recover_in(recov),
        .secure_error_irq_enable_in(en), .irq_enable_acknowledge_in(enack),
        .msg_done_in(done), .msg_abort_in(abt), .msg_req_out(req), .msg_addr_out(maddr),
        .wired_irq_out(irq), .error_active_out(act),
        .command_consumer_reason_code_out(reason_code), .command_stop_out(ctstop),
        .traffic_stop_out(trstop), .event_stop_out(evstop), .service_failure_mode_out(fmode));
    sgerr_msg_model u_msg (.core_clk_in, .rst_in, .msg_req_in(req),
        .abort_mode_in(abort_mode), .delay_in(dly), .msg_done_out(done), .msg_abort_out(abt));

    // ----------------------------------------------------------------
    // clock, watchdog and helpers
    // ----------------------------------------------------------------
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    initial begin
        repeat (3000) @(posedge core_clk_in);
        num_errors++;
        give_verdict();
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic n, input logic [15:0] a, input logic [31:0] d);
        sel <= 1'b1;
        wr <= w;
        ns <= n;
        addr <= a;
        wd <= d;
        @(posedge core_clk_in);
        sel <= 1'b0;
        @(posedge core_clk_in);
        q = rdata;
        chk("ready", ready, 1'b1);
    endtask
    task automatic rd_chk(input logic n, input logic [15:0] a, input logic [31:0] e, input string s);
        acc(1'b0, n, a, 32'h0);
        chk(s, q, e);
    endtask
    task automatic fl(input int b);
        evp[b] <= 1'b1;
        @(posedge core_clk_in);
        evp[b] <= 1'b0;
        if (!pend[b]) begin
            sv[b] = ~sv[b];
            pend[b] = 1'b1;
        end
        @(posedge core_clk_in);
    endtask
    task automatic ack(input logic [9:0] keep);
        acc(1'b1, 1'b0, `SGERR_OFF_ACK, {22'h0, sv ^ keep});
        pend = keep;
    endtask
    task automatic watch(input int n);
        saw_req = 1'b0;
        saw_irq = 1'b0;
        repeat (n) begin
            @(posedge core_clk_in);
            saw_req |= req;
            saw_irq |= irq;
            if (req) seen_addr = maddr;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_in, sel, wr, ns, addr, wd, evp, en, enack, recov, abort_mode} = {1'b1, 65'h0};
        {dly, rs, sv, pend, num_errors, checks_done} = {4'h3, 7'h2B, 20'h0, 64'h0};
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        rd_chk(1'b0, `SGERR_OFF_STATUS, 32'h0, "status reset");
        rd_chk(1'b0, `SGERR_OFF_ACK, 32'h0, "ack reset");
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            fl(bits[i]);
            chk("active", act, 10'h001 << bits[i]);
            rs <= 7'h11;
            fl(bits[i]);
            rd_chk(1'b0, `SGERR_OFF_STATUS, {22'h0, sv}, "status");
            if (bits[i] == 0) chk("reason stop", {reason_code, ctstop}, {7'h2B, 1'b1});
            acc(1'b1, 1'b0, `SGERR_OFF_ACK, {22'h0, sv} | 32'hFFFF_FC4A);
            pend = 10'h0;
            rd_chk(1'b0, `SGERR_OFF_ACK, {22'h0, sv}, "ack");
            chk("cleared", act, 10'h000);
        end
        $display("test toggle pairs done");
        fl(2);
        rd_chk(1'b1, `SGERR_OFF_STATUS, 32'h0, "ns status");
        acc(1'b1, 1'b1, `SGERR_OFF_ACK, {22'h0, sv});
        chk("ns ack", act, 10'h004);
        rd_chk(1'b0, 16'h8070, 32'h0, "unmapped");
        ack(10'h0);
        acc(1'b1, 1'b0, `SGERR_OFF_MADDR_LO, 32'hFFFF_FFFF);
        acc(1'b1, 1'b0, `SGERR_OFF_MADDR_HI, 32'hFFFF_FFFF);
        rd_chk(1'b0, `SGERR_OFF_MADDR_LO, 32'hFFFF_FFFC, "addr lo");
        rd_chk(1'b0, `SGERR_OFF_MADDR_HI, 32'h0000_FFFF, "addr hi");
        en <= 1'b1;
        acc(1'b1, 1'b0, `SGERR_OFF_MADDR_LO, 32'h0);
        {en, enack} <= 2'b01;
        acc(1'b1, 1'b0, `SGERR_OFF_MADDR_HI, 32'h0);
        rd_chk(1'b0, `SGERR_OFF_MADDR_LO, 32'hFFFF_FFFC, "guard lo");
        rd_chk(1'b0, `SGERR_OFF_MADDR_HI, 32'h0000_FFFF, "guard hi");
        $display("test registers done");
        en <= 1'b1;
        fl(2);
        watch(12);
        chk("msg sent", saw_req, 1'b1);
        chk("msg addr", seen_addr, 64'h0000_FFFF_FFFF_FFFC);
        ack(10'h0);
        abort_mode <= 1'b1;
        dly <= 4'h0;
        fl(4);
        watch(20);
        sv[7] = ~sv[7];
        pend[7] = 1'b1;
        chk("abort flag", act, 10'h090);
        abort_mode <= 1'b0;
        dly <= 4'h3;
        ack(10'h080);
        fl(5);
        watch(12);
        chk("msg with abort flag", saw_req, 1'b1);
        ack(10'h0);
        {en, enack} <= 2'b00;
        acc(1'b1, 1'b0, `SGERR_OFF_MADDR_LO, 32'h0);
        acc(1'b1, 1'b0, `SGERR_OFF_MADDR_HI, 32'h0);
        {en, enack} <= 2'b11;
        fl(9);
        watch(8);
        chk("wired not msg", {saw_req, saw_irq}, 2'b01);
        ack(10'h0);
        $display("test notify done");
        fl(8);
        chk("stops", {trstop, evstop, ctstop, fmode}, 4'hF);
        ack(10'h0);
        chk("failure kept", {act[8], fmode}, 2'b01);
        recov <= 1'b1;
        @(posedge core_clk_in);
        recov <= 1'b0;
        @(posedge core_clk_in);
        chk("recovered", fmode, 1'b0);
        $display("test failure mode done");
        give_verdict();
    end
endmodule // tb
